// *** counter_array_pkg.sv ***
// Purpose: constants and carriers for the counter array register block
// Assumes: AHB-Lite word registers, register index times four is the byte address
// Notes:   all registers are eight bits wide in the low byte lane
// How it works
// - overflow sets status bit 7, held until software clears it
// - overflow on 16-bit wrap, or on every low-byte wrap when byte mode selected
// - counter equal to compare-interrupt value sets status bit 6, sticky
// - channel conditions set status bits 5..0, cleared only by software
// - counter high/low reads return live counter bits 15:8 and 7:0
// - each counter-low read copies the whole counter into both snapshot bytes
// - two read/write reload bytes supply the reload value in auto-reload mode
// - snapshot addresses read snapshot, writes load buffered compare-interrupt bytes
// - all six channels share the 16-bit counter, each configured on its own
// - compare match: level/toggle 00 hold, 01 toggle, 10 low, 11 high
// - level and toggle settings touch only the pin, never the flag
// - pwm modes ignore level bit; toggle bit forces the pin high, except in windowed pwm where it inverts the pin
// - config bit 6 enables the channel comparator
// - config bit 5 rising capture, bit 4 falling, both means either edge
// - match-control set: match sets channel flag; windowed pwm adds second edge
// - config bit 1 enables pwm with the waveform on the pin
// - config bit 0 lets the channel raise a request; clear means none
// - every register of the block resets to zero
// - count-match flag requests an interrupt only while its enable is set
// - comparator trigger enable lets comparator events copy counter to snapshot
// - auto-reload overflow loads both reload bytes, or low byte in 8-bit mode
package counter_array_pkg;

   // ---------------------------------------------------------------
   // register indices
   // ---------------------------------------------------------------
   localparam logic [15:0] COUNTER_LOW_IDX   = 16'h00d9;
   localparam logic [15:0] COUNTER_HIGH_IDX  = 16'h00e9;
   localparam logic [15:0] FLAGS_IDX         = 16'h00e1;
   localparam logic [15:0] SNAP_LOW_IDX      = 16'h00f2;
   localparam logic [15:0] SNAP_HIGH_IDX     = 16'h00f3;
   localparam logic [15:0] RELOAD_LOW_IDX    = 16'ha0a6;
   localparam logic [15:0] RELOAD_HIGH_IDX   = 16'ha0a7;
   localparam logic [15:0] COUNTER_CTRL_IDX  = 16'h0100;
   localparam int          NUM_CHANNELS      = 6;
   localparam logic [15:0] CFG_IDX [NUM_CHANNELS] =
      '{16'h00b2, 16'h00b3, 16'h00b4, 16'h00b5, 16'h00b6, 16'h00b7};
   localparam logic [15:0] VAL_LO_IDX [NUM_CHANNELS] =
      '{16'h00d2, 16'h00d4, 16'h00d6, 16'h00e2, 16'h00e4, 16'h00e6};
   localparam logic [15:0] VAL_HI_IDX [NUM_CHANNELS] =
      '{16'h00d3, 16'h00d5, 16'h00d7, 16'h00e3, 16'h00e5, 16'h00e7};

   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int          OVF_BIT     = 7;
   localparam int          CMATCH_BIT  = 6;
   localparam logic [7:0]  REG_RESET   = 8'h00;
   localparam logic [15:0] CNT_RESET   = 16'h0000;
   localparam logic [7:0]  BYTE_MAX    = 8'hff;
   localparam logic [15:0] WORD_MAX    = 16'hffff;

   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic idle_stop;
      logic auto_reload_enable;
      logic count8;
      logic byte_overflow_sel;
      logic counter_enable;
      logic overflow_irq_en;
      logic count_match_irq_en;
      logic comparator_snap_trigger;
   } counter_ctrl_t;

   typedef struct packed {
      logic out_level;
      logic comparator_enable;
      logic rising_capture;
      logic falling_capture;
      logic match_control;
      logic toggle_force;
      logic pwm_enable;
      logic channel_irq_enable;
   } channel_config_t;

endpackage : counter_array_pkg

// *** counter_array_regs.sv ***
// Purpose: counter array main counter, status, snapshot, reload and six channels
// Assumes: one clock, AHB-Lite slave with one wait state on every transfer
// Notes:   channel pins are sampled as synchronous inputs
//
// Design decision made here: the AHB-Lite register port.
module counter_array_regs
   import counter_array_pkg::*;
#(
   parameter int CHANNELS = NUM_CHANNELS
) (
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic      [31:0]         hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire logic                cpu_idle,
   input  wire logic                comparator_event,
   input  wire logic [CHANNELS-1:0] channel_pin_in,
   output logic      [CHANNELS-1:0] channel_pin,
   output logic                     irq_req
);

   if (CHANNELS != NUM_CHANNELS) begin : g_bad_channels
      $error("channel count is fixed by the register map");
   end

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   // every transfer gets one wait state, so writes land before any
   // following read is answered and the read mux is a clean flop
   logic        pend_ff;
   logic        write_ff;
   logic [29:0] awd_ff;
   logic [31:0] hrdata_ff;
   logic        hreadyout_ff;
   logic [7:0]  rd_byte;
   logic        wr_now;
   logic        rd_now;
   logic [7:0]  wbyte;

   assign wr_now = pend_ff & write_ff;
   assign rd_now = pend_ff & ~write_ff;
   assign wbyte  = hwdata[7:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_ff      <= 1'b0;
         write_ff     <= 1'b0;
         awd_ff       <= 30'h0;
         hreadyout_ff <= 1'b1;
      end else if (hsel && htrans[1] && hready) begin
         pend_ff      <= 1'b1;
         write_ff     <= hwrite;
         awd_ff       <= haddr[31:2];
         hreadyout_ff <= 1'b0;
      end else begin
         pend_ff      <= 1'b0;
         hreadyout_ff <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0;
      end else if (rd_now) begin
         hrdata_ff <= {24'h0, rd_byte};
      end
   end

   assign hrdata    = hrdata_ff;
   assign hreadyout = hreadyout_ff;
   assign hresp     = 1'b0;

   function automatic logic hit(input logic [29:0] a, input logic [15:0] idx);
      hit = (a == {14'h0, idx});
   endfunction : hit

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   counter_ctrl_t ctrl_ff;
   logic          run;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_ff <= counter_ctrl_t'(REG_RESET);
      end else if (wr_now && hit(awd_ff, COUNTER_CTRL_IDX)) begin
         ctrl_ff <= counter_ctrl_t'(wbyte);
      end
   end

   // idle stop pauses counting but keeps the value
   assign run = ctrl_ff.counter_enable & ~(ctrl_ff.idle_stop & cpu_idle);

   // ---------------------------------------------------------------
   // main counter
   // ---------------------------------------------------------------
   logic [15:0] cnt_ff;
   logic [7:0]  rld_lo_ff;
   logic [7:0]  rld_hi_ff;
   logic        low_wrap;
   logic        ovf;

   assign low_wrap = run & (cnt_ff[7:0] == BYTE_MAX);
   assign ovf = (ctrl_ff.byte_overflow_sel | ctrl_ff.count8) ? low_wrap
              : (run & (cnt_ff == WORD_MAX));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff <= CNT_RESET;
      end else if (!ctrl_ff.counter_enable) begin
         cnt_ff <= CNT_RESET;
      end else if (ovf && ctrl_ff.auto_reload_enable) begin
         cnt_ff <= ctrl_ff.count8 ? {cnt_ff[15:8], rld_lo_ff} : {rld_hi_ff, rld_lo_ff};
      end else if (run && ctrl_ff.count8) begin
         cnt_ff <= {cnt_ff[15:8], cnt_ff[7:0] + 8'h01};
      end else if (run) begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end

   // counter readback indices have no write path at all
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rld_lo_ff <= REG_RESET;
         rld_hi_ff <= REG_RESET;
      end else begin
         if (wr_now && hit(awd_ff, RELOAD_LOW_IDX)) begin
            rld_lo_ff <= wbyte;
         end
         if (wr_now && hit(awd_ff, RELOAD_HIGH_IDX)) begin
            rld_hi_ff <= wbyte;
         end
      end
   end

   // ---------------------------------------------------------------
   // snapshot and count-match value
   // ---------------------------------------------------------------
   logic [15:0] snap_ff;
   logic [15:0] cmv_buf_ff;
   logic [15:0] cmv_act_ff;
   logic        cmatch;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         snap_ff <= CNT_RESET;
      end else if (rd_now && hit(awd_ff, COUNTER_LOW_IDX)) begin
         snap_ff <= cnt_ff;
      end else if (comparator_event && ctrl_ff.comparator_snap_trigger) begin
         snap_ff <= cnt_ff;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmv_buf_ff <= CNT_RESET;
      end else begin
         if (wr_now && hit(awd_ff, SNAP_LOW_IDX)) begin
            cmv_buf_ff[7:0] <= wbyte;
         end
         if (wr_now && hit(awd_ff, SNAP_HIGH_IDX)) begin
            cmv_buf_ff[15:8] <= wbyte;
         end
      end
   end

   // buffered so a half-written value never produces a stray match
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmv_act_ff <= CNT_RESET;
      end else if (ovf || !ctrl_ff.counter_enable) begin
         cmv_act_ff <= cmv_buf_ff;
      end
   end

   assign cmatch = run & (cnt_ff == cmv_act_ff);

   // ---------------------------------------------------------------
   // channels
   // ---------------------------------------------------------------
   logic [CHANNELS-1:0]    ch_set;
   logic [CHANNELS-1:0]    ch_irq_en;
   logic [CHANNELS*8-1:0]  ch_cfg_all;
   logic [CHANNELS*16-1:0] ch_val_all;

   for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
      channel_config_t cfg_ff;
      logic [15:0]     vb_ff;
      logic [15:0]     va_ff;
      logic            pin_q_ff;
      logic            pin_ff;
      logic            wr_cfg;
      logic            wr_lo;
      logic            wr_hi;
      logic            edge_hit;
      logic            cap_mode;
      logic            cmp_mode;
      logic            pwm8_mode;
      logic            pwm16_mode;
      logic            windowed_pwm_mode;
      logic            eq16;
      logic            eq_lo;
      logic            eq_hi;
      logic            win;

      assign wr_cfg = wr_now && hit(awd_ff, CFG_IDX[i]);
      assign wr_lo  = wr_now && hit(awd_ff, VAL_LO_IDX[i]);
      assign wr_hi  = wr_now && hit(awd_ff, VAL_HI_IDX[i]);

      assign cap_mode   = (cfg_ff.rising_capture | cfg_ff.falling_capture)
                          & ~cfg_ff.pwm_enable;
      assign cmp_mode   = cfg_ff.comparator_enable & ~cfg_ff.rising_capture
                          & ~cfg_ff.falling_capture & ~cfg_ff.pwm_enable;
      assign pwm8_mode  = cfg_ff.comparator_enable & cfg_ff.pwm_enable
                          & ~cfg_ff.rising_capture & ~cfg_ff.falling_capture;
      assign pwm16_mode = cfg_ff.comparator_enable & cfg_ff.pwm_enable
                          & cfg_ff.rising_capture & ~cfg_ff.falling_capture;
      assign windowed_pwm_mode  = cfg_ff.comparator_enable & cfg_ff.pwm_enable
                          & cfg_ff.rising_capture & cfg_ff.falling_capture;

      assign edge_hit = (cfg_ff.rising_capture & channel_pin_in[i] & ~pin_q_ff)
                      | (cfg_ff.falling_capture & ~channel_pin_in[i] & pin_q_ff);

      // time base is the shared counter for every channel
      assign eq16  = run & (cnt_ff == va_ff);
      assign eq_lo = run & (cnt_ff[7:0] == va_ff[7:0]);
      assign eq_hi = run & (cnt_ff[7:0] == va_ff[15:8]);
      assign win   = (cnt_ff[7:0] > va_ff[7:0]) & ~(cnt_ff[7:0] > va_ff[15:8]);

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            cfg_ff <= channel_config_t'(REG_RESET);
         end else if (wr_cfg) begin
            cfg_ff <= channel_config_t'(wbyte);
         end else if (wr_lo && cmp_mode) begin
            cfg_ff.comparator_enable <= 1'b0;
         end else if (wr_hi && (cfg_ff[7:1] != 7'h00)) begin
            cfg_ff.comparator_enable <= 1'b1;
         end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            pin_q_ff <= 1'b0;
         end else begin
            pin_q_ff <= channel_pin_in[i];
         end
      end

      // a capture edge wins over a bus write in the same cycle
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            vb_ff <= CNT_RESET;
         end else if (cap_mode && edge_hit) begin
            vb_ff <= cnt_ff;
         end else begin
            if (wr_lo) begin
               vb_ff[7:0] <= wbyte;
            end
            if (wr_hi) begin
               vb_ff[15:8] <= wbyte;
            end
         end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            va_ff <= CNT_RESET;
         end else if (!ctrl_ff.counter_enable) begin
            va_ff <= vb_ff;
         end else if ((pwm8_mode || windowed_pwm_mode) ? low_wrap : ovf) begin
            va_ff <= vb_ff;
         end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            pin_ff <= 1'b0;
         end else if (cmp_mode && eq16) begin
            case ({cfg_ff.out_level, cfg_ff.toggle_force})
               2'b01:   pin_ff <= ~pin_ff;
               2'b10:   pin_ff <= 1'b0;
               2'b11:   pin_ff <= 1'b1;
               default: pin_ff <= pin_ff;
            endcase
         end else if (pwm8_mode) begin
            pin_ff <= cfg_ff.toggle_force | (cnt_ff[7:0] > va_ff[7:0]);
         end else if (pwm16_mode) begin
            pin_ff <= cfg_ff.toggle_force | (cnt_ff > va_ff);
         end else if (windowed_pwm_mode) begin
            pin_ff <= cfg_ff.toggle_force ^ win;
         end
      end

      // pin settings never enter the flag terms
      always_comb begin
         ch_set[i] = 1'b0;
         if (cap_mode) begin
            ch_set[i] = edge_hit;
         end else if (cmp_mode) begin
            ch_set[i] = cfg_ff.match_control & eq16;
         end else if (pwm8_mode) begin
            ch_set[i] = cfg_ff.channel_irq_enable & eq_lo;
         end else if (pwm16_mode) begin
            ch_set[i] = cfg_ff.channel_irq_enable & eq16;
         end else if (windowed_pwm_mode) begin
            ch_set[i] = cfg_ff.channel_irq_enable
                        & (eq_lo | (cfg_ff.match_control & eq_hi));
         end
      end

      assign channel_pin[i]             = pin_ff;
      assign ch_irq_en[i]               = cfg_ff.channel_irq_enable;
      assign ch_cfg_all[i*8 +: 8]       = cfg_ff;
      assign ch_val_all[i*16 +: 16]     = vb_ff;
   end

   // ---------------------------------------------------------------
   // status flags and request
   // ---------------------------------------------------------------
   logic [7:0] flags_ff;
   logic [7:0] hw_set;
   logic [7:0] sw_keep;
   logic       irq_ff;

   assign hw_set  = {ovf, cmatch, ch_set};
   // software writes zero to clear; ones leave a flag untouched
   assign sw_keep = (wr_now && hit(awd_ff, FLAGS_IDX)) ? wbyte : 8'hff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_ff <= REG_RESET;
      end else begin
         flags_ff <= (flags_ff & sw_keep) | hw_set;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= (flags_ff[OVF_BIT] & ctrl_ff.overflow_irq_en)
                 | (flags_ff[CMATCH_BIT] & ctrl_ff.count_match_irq_en)
                 | (|(flags_ff[5:0] & ch_irq_en));
      end
   end

   assign irq_req = irq_ff;

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb begin
      rd_byte = 8'h00;
      if (hit(awd_ff, COUNTER_LOW_IDX)) begin
         rd_byte = cnt_ff[7:0];
      end else if (hit(awd_ff, COUNTER_HIGH_IDX)) begin
         rd_byte = cnt_ff[15:8];
      end else if (hit(awd_ff, FLAGS_IDX)) begin
         rd_byte = flags_ff;
      end else if (hit(awd_ff, SNAP_LOW_IDX)) begin
         rd_byte = snap_ff[7:0];
      end else if (hit(awd_ff, SNAP_HIGH_IDX)) begin
         rd_byte = snap_ff[15:8];
      end else if (hit(awd_ff, RELOAD_LOW_IDX)) begin
         rd_byte = rld_lo_ff;
      end else if (hit(awd_ff, RELOAD_HIGH_IDX)) begin
         rd_byte = rld_hi_ff;
      end else if (hit(awd_ff, COUNTER_CTRL_IDX)) begin
         rd_byte = ctrl_ff;
      end
      for (int k = 0; k < CHANNELS; k++) begin
         if (hit(awd_ff, CFG_IDX[k])) begin
            rd_byte = ch_cfg_all[k*8 +: 8];
         end
         if (hit(awd_ff, VAL_LO_IDX[k])) begin
            rd_byte = ch_val_all[k*16 +: 8];
         end
         if (hit(awd_ff, VAL_HI_IDX[k])) begin
            rd_byte = ch_val_all[k*16+8 +: 8];
         end
      end
   end

   // hsize is unused: only whole-word transfers reach this slave
   logic unused_ok;
   assign unused_ok = &{1'b0, hsize, hwdata[31:8]};

endmodule : counter_array_regs

// *** counter_array_chk.sv ***
// Purpose: bus and register property checks for the counter array block
// Assumes: one wait state per transfer, byte registers in bits 7:0
// Notes:   the counter is not visible here, so checks are relational
module counter_array_chk
   import counter_array_pkg::*;
#(
   parameter int CHANNELS = NUM_CHANNELS
) (
   input wire logic                hclk,
   input wire logic                hresetn,
   input wire logic                hsel,
   input wire logic [31:0]         haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic [31:0]         hwdata,
   input wire logic                hready,
   input wire logic [31:0]         hrdata,
   input wire logic                hreadyout,
   input wire logic                hresp,
   input wire logic                comparator_event,
   input wire logic [CHANNELS-1:0] channel_pin,
   input wire logic                irq_req
);
   // ---------------------------------------------------------------
   // transfer tracking
   // ---------------------------------------------------------------
   logic        pend_ff;
   logic        pwr_ff;
   logic        snap_ok_ff;
   logic [15:0] pidx_ff;
   logic [7:0]  cl_ff;
   logic [7:0]  rl_ff;
   logic        take;
   logic        done;
   assign take = hsel && htrans[1] && hready;
   assign done = pend_ff && hreadyout;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_ff <= 1'b0;
         pwr_ff  <= 1'b0;
         pidx_ff <= 16'h0000;
      end else if (take) begin
         pend_ff <= 1'b1;
         pwr_ff  <= hwrite;
         pidx_ff <= haddr[17:2];
      end else if (done) begin
         pend_ff <= 1'b0;
      end
   end
   // a comparator event may overwrite the snapshot, so it voids the copy
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         snap_ok_ff <= 1'b0;
         cl_ff      <= 8'h00;
      end else if (comparator_event) begin
         snap_ok_ff <= 1'b0;
      end else if (done && !pwr_ff && pidx_ff == COUNTER_LOW_IDX) begin
         snap_ok_ff <= 1'b1;
         cl_ff      <= hrdata[7:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rl_ff <= 8'h00;
      end else if (done && pwr_ff && pidx_ff == RELOAD_LOW_IDX) begin
         rl_ff <= hwdata[7:0];
      end
   end
   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_one_wait;
      take |=> !hreadyout ##1 hreadyout;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait state missing");
   property p_ready_one;
      !hreadyout |=> hreadyout;
   endproperty
   a_ready_one: assert property (p_ready_one) else $error("ready low too long");
   property p_upper_zero;
      done |-> hrdata[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
   property p_hrdata_hold;
      $changed(hrdata) |-> done && !pwr_ff;
   endproperty
   a_hrdata_hold: assert property (p_hrdata_hold) else $error("read data moved");
   property p_rst_quiet;
      $rose(hresetn) |-> hrdata == 32'h0 && hreadyout && !irq_req && channel_pin == '0;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not clear");
   property p_snap_match;
      done && !pwr_ff && pidx_ff == SNAP_LOW_IDX && snap_ok_ff |-> hrdata[7:0] == cl_ff;
   endproperty
   a_snap_match: assert property (p_snap_match) else $error("snapshot differs");
   property p_reload_echo;
      done && !pwr_ff && pidx_ff == RELOAD_LOW_IDX |-> hrdata[7:0] == rl_ff;
   endproperty
   a_reload_echo: assert property (p_reload_echo) else $error("reload differs");
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
endmodule : counter_array_chk

bind counter_array_regs counter_array_chk #(.CHANNELS(CHANNELS)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .comparator_event(comparator_event),
   .channel_pin(channel_pin), .irq_req(irq_req));

// *** ahb_host.sv ***
// Purpose: single-word bus master standing in for cpu software
// Assumes: tasks are entered just after a rising edge
// Notes:   waits are bounded; an expired wait is counted in tmo
module ahb_host (
   input  wire logic        hclk,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 1ns;
   int tmo = 0;
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h0;
   end
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1 && n < 50) begin
         @(posedge hclk);
         n++;
      end
      if (n >= 50) tmo++;
   endtask : wait_rdy
   task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
      hsel   <= 1'b1;
      haddr  <= {14'h0, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy;
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      wait_rdy;
      rd = hrdata[7:0];
   endtask : xfer
endmodule : ahb_host

// *** tb.sv ***
// Purpose: self-checking bench for the counter array register block
// Assumes: counter starts at zero when enabled, one wait state per transfer
// Notes:   byte overflow mode keeps the overflow wait short
module tb
   import counter_array_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [5:0]  pin_in = 6'h00;
   logic        cev = 1'b0;
   logic [5:0]  pin, pre, e;
   logic [7:0]  seed, v, r;
   int          err_count = 0;
   int          checks_done = 0;
   localparam logic [15:0] RIDX [7] = '{COUNTER_LOW_IDX, COUNTER_HIGH_IDX, FLAGS_IDX,
      SNAP_LOW_IDX, SNAP_HIGH_IDX, RELOAD_LOW_IDX, RELOAD_HIGH_IDX};
   always #25 hclk = ~hclk;
   counter_array_regs #(.CHANNELS(6)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .cpu_idle(1'b0), .comparator_event(cev), .channel_pin_in(pin_in),
      .channel_pin(pin), .irq_req(irq));
   ahb_host u_host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [15:0] i, input logic [7:0] d);
      logic [7:0] x;
      u_host.xfer(1'b1, i, d, x);
   endtask : wr
   task automatic rd(input logic [15:0] i, output logic [7:0] d);
      u_host.xfer(1'b0, i, 8'h00, d);
   endtask : rd
   task automatic rdchk(input logic [15:0] i, input logic [7:0] exp);
      logic [7:0] d;
      rd(i, d);
      chk({24'h0, d}, {24'h0, exp});
   endtask : rdchk
   task automatic report_and_stop;
      err_count += u_host.tmo;
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   initial begin
      #5000000;
      err_count++;
      report_and_stop;
   end
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   initial begin
      seed = 8'h54;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      foreach (CFG_IDX[k]) rdchk(CFG_IDX[k], 8'h00);
      foreach (RIDX[k]) rdchk(RIDX[k], 8'h00);
      for (int k = 0; k < 8; k++) begin
         seed = lfsr(seed);
         wr(k < 6 ? CFG_IDX[k] : RIDX[k - 1], seed);
         rdchk(k < 6 ? CFG_IDX[k] : RIDX[k - 1], seed);
      end
      wr(COUNTER_LOW_IDX, 8'hff);
      wr(COUNTER_HIGH_IDX, 8'hff);
      wr(16'h0300, 8'ha5);
      rdchk(COUNTER_LOW_IDX, 8'h00);
      rdchk(COUNTER_HIGH_IDX, 8'h00);
      rdchk(16'h0300, 8'h00);
      // compare channels take each out_level/toggle pair once
      for (int k = 0; k < 5; k++) begin
         wr(VAL_LO_IDX[k], k == 4 ? 8'h80 : 8'h20);
         wr(VAL_HI_IDX[k], 8'h00);
         wr(CFG_IDX[k], k == 4 ? 8'h47 : {k[1], 3'b100, 1'b1, k[0], 2'b01});
      end
      wr(CFG_IDX[5], 8'h11);
      wr(SNAP_LOW_IDX, 8'h40);
      wr(SNAP_HIGH_IDX, 8'h00);
      wr(FLAGS_IDX, 8'h00);
      rdchk(FLAGS_IDX, 8'h00);
      pre = pin;
      wr(COUNTER_CTRL_IDX, 8'h0b);
      rd(COUNTER_LOW_IDX, v);
      rd(COUNTER_LOW_IDX, r);
      chk({24'h0, r}, {24'h0, v + 8'h03});
      rdchk(SNAP_LOW_IDX, r);
      cev <= 1'b1;
      @(posedge hclk);
      cev <= 1'b0;
      rdchk(SNAP_LOW_IDX, r + 8'h05);
      repeat (80) @(posedge hclk);
      e = {pre[5], 1'b1, 1'b1, 1'b0, ~pre[1], pre[0]};
      chk({26'h0, pin[4:0]}, {26'h0, e[4:0]});
      rdchk(FLAGS_IDX, 8'h4f);
      chk({31'h0, irq}, 32'h1);
      pin_in <= 6'h20;
      repeat (3) @(posedge hclk);
      rdchk(FLAGS_IDX, 8'h4f);
      pin_in <= 6'h00;
      repeat (3) @(posedge hclk);
      rdchk(FLAGS_IDX, 8'h6f);
      wr(COUNTER_CTRL_IDX, 8'h18);
      repeat (300) @(posedge hclk);
      rd(FLAGS_IDX, r);
      chk({31'h0, r[7]}, 32'h1);
      wr(COUNTER_CTRL_IDX, 8'h00);
      wr(FLAGS_IDX, 8'h7f);
      rd(FLAGS_IDX, r);
      chk({30'h0, r[7:6]}, 32'h1);
      report_and_stop;
   end
endmodule : tb
